// *** src/ext_irq_pkg.sv ***
// constants and types shared by the external interrupt bank
package ext_irq_pkg;
    localparam int unsigned LINE_COUNT = 8;
    localparam int unsigned ADDR_WIDTH = 8;
    localparam int unsigned DATA_WIDTH = 8;

    localparam logic [7:0] PENDING_FLAGS_ADDR  = 8'hf0;
    localparam logic [7:0] ENABLES_ADDR        = 8'hf1;
    localparam logic [7:0] PRIORITIES_ADDR     = 8'hf2;
    localparam logic [7:0] TRIGGER_SELECT_ADDR = 8'hf3;
    localparam logic [7:0] POLARITY_ADDR       = 8'hf4;

    localparam logic [7:0] PENDING_FLAGS_RESET  = 8'h00;
    localparam logic [7:0] ENABLES_RESET        = 8'h00;
    localparam logic [7:0] PRIORITIES_RESET     = 8'h00;
    localparam logic [7:0] TRIGGER_SELECT_RESET = 8'h00;
    localparam logic [7:0] POLARITY_RESET       = 8'h00;
    localparam logic [7:0] READ_DATA_RESET      = 8'h00;

    // vector of line seven, and the step between consecutive lines
    localparam logic [7:0] VECTOR_BASE = 8'h6b;
    localparam logic [7:0] VECTOR_STEP = 8'h08;
    localparam logic [2:0] LINE_NONE   = 3'h0;

    // trigger select and polarity encodings
    localparam logic TRIGGER_EDGE  = 1'b1;
    localparam logic TRIGGER_LEVEL = 1'b0;
    localparam logic POLARITY_HIGH = 1'b1;
endpackage : ext_irq_pkg

// *** src/ext_irq_line_detect.sv ***
// per-line request detector: polarity, edge detection and level sensing
`timescale 1ns/100ps
module ext_irq_line_detect
    import ext_irq_pkg::*;
(
    // clock and reset
    input  wire logic clock_in,
    input  wire logic srst_in,
    // configuration
    input  wire logic edge_mode_in,
    input  wire logic rising_high_in,
    // request pin
    input  wire logic request_in,
    // detection results
    output logic      active_level_out,
    output logic      edge_seen_out
);
    typedef struct packed {
        logic prev_active;
    } detect_state_t;

    detect_state_t state_reg;
    detect_state_t state_next;
    logic          active_now;

    // polarity folds both senses onto one active-high view of the pin
    assign active_now = rising_high_in ? request_in : ~request_in;

    always_comb begin
        state_next             = state_reg;
        state_next.prev_active = active_now;
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign active_level_out = active_now;
    // an active first sample after reset counts as an edge, since reset clears prev_active
    assign edge_seen_out    = edge_mode_in & active_now & ~state_reg.prev_active;
endmodule : ext_irq_line_detect

// *** src/ext_irq_bank.sv ***
// external interrupt bank for lines seven to fourteen, with special function registers
`timescale 1ns/100ps
// Summary of operation
// - in level mode each pending flag copies its active request pin on every clock.
// - in edge mode a pending flag stays set until software writes a one to its bit; a zero leaves it.
// - software can never set a pending flag; only the request lines set flags.
// - each line has a fixed vector, 0x6b for line seven rising by eight up to 0xa3 for line fourteen.
// - a trigger select bit of one picks edge mode and zero picks level mode, bits in line order.
// - a polarity bit of one picks rising edge or high level, zero picks falling edge or low level.
module ext_irq_bank
    import ext_irq_pkg::*;
(
    // clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  srst_in,
    // special function register port
    input  wire logic [ADDR_WIDTH-1:0] sfr_addr_in,
    input  wire logic                  sfr_write_in,
    input  wire logic                  sfr_read_in,
    input  wire logic [DATA_WIDTH-1:0] sfr_wdata_in,
    output logic      [DATA_WIDTH-1:0] sfr_rdata_out,
    // request pins, bit zero is line seven
    input  wire logic [LINE_COUNT-1:0] ext_request_lines_seven_to_fourteen_in,
    // requests to the core arbitration
    output logic                       irq_high_out,
    output logic                       irq_low_out,
    output logic      [7:0]            irq_vector_out,
    output logic      [LINE_COUNT-1:0] irq_lines_out
);
    typedef struct packed {
        logic [7:0] pending;
        logic [7:0] enables;
        logic [7:0] priorities;
        logic [7:0] trigger;
        logic [7:0] polarity;
        logic [7:0] rdata;
        logic       high;
        logic       low;
        logic [7:0] vector;
        logic [7:0] lines;
    } bank_state_t;

    bank_state_t           state_reg;
    bank_state_t           state_next;
    logic [LINE_COUNT-1:0] active_level;
    logic [LINE_COUNT-1:0] edge_seen;

    ////////////////////////////////////////////////////////////////////////////
    // per-line detectors
    genvar g;
    generate
        for (g = 0; g < LINE_COUNT; g++) begin : g_line
            ext_irq_line_detect u_detect (
                .clock_in         (clock_in),
                .srst_in          (srst_in),
                .edge_mode_in     (state_reg.trigger[g]),
                .rising_high_in   (state_reg.polarity[g]),
                .request_in       (ext_request_lines_seven_to_fourteen_in[g]),
                .active_level_out (active_level[g]),
                .edge_seen_out    (edge_seen[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [7:0] clear_mask;
        logic [7:0] req;
        logic [7:0] sel;
        logic       found;
        clear_mask = '0;
        req        = '0;
        sel        = '0;
        found      = 1'b0;
        state_next = state_reg;

        if (sfr_write_in) begin
            unique case (sfr_addr_in)
                PENDING_FLAGS_ADDR:  clear_mask = sfr_wdata_in;
                ENABLES_ADDR:        state_next.enables = sfr_wdata_in;
                PRIORITIES_ADDR:     state_next.priorities = sfr_wdata_in;
                TRIGGER_SELECT_ADDR: state_next.trigger = sfr_wdata_in;
                POLARITY_ADDR:       state_next.polarity = sfr_wdata_in;
                default:             clear_mask = '0;
            endcase
        end

        for (int i = 0; i < LINE_COUNT; i++) begin
            if (state_reg.trigger[i] == TRIGGER_LEVEL) begin
                // level flags follow the pin, so a clear write has no lasting effect
                state_next.pending[i] = active_level[i];
            end else begin
                // a new edge beats a clear in the same cycle
                state_next.pending[i] = edge_seen[i] | (state_reg.pending[i] & ~clear_mask[i]);
            end
        end

        // reads of unmapped addresses return zero
        state_next.rdata = READ_DATA_RESET;
        if (sfr_read_in) begin
            unique case (sfr_addr_in)
                PENDING_FLAGS_ADDR:  state_next.rdata = state_reg.pending;
                ENABLES_ADDR:        state_next.rdata = state_reg.enables;
                PRIORITIES_ADDR:     state_next.rdata = state_reg.priorities;
                TRIGGER_SELECT_ADDR: state_next.rdata = state_reg.trigger;
                POLARITY_ADDR:       state_next.rdata = state_reg.polarity;
                default:             state_next.rdata = READ_DATA_RESET;
            endcase
        end

        req              = state_reg.pending & state_reg.enables;
        state_next.lines = req;
        state_next.high  = |(req & state_reg.priorities);
        state_next.low   = |(req & ~state_reg.priorities);

        // high group first, then lowest line number within the group
        sel = (|(req & state_reg.priorities)) ? (req & state_reg.priorities) : req;
        state_next.vector = VECTOR_BASE;
        for (int i = 0; i < LINE_COUNT; i++) begin
            if (sel[i] && !found) begin
                found             = 1'b1;
                state_next.vector = VECTOR_BASE + VECTOR_STEP * 8'(i);
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_reg.pending    <= PENDING_FLAGS_RESET;
            state_reg.enables    <= ENABLES_RESET;
            state_reg.priorities <= PRIORITIES_RESET;
            state_reg.trigger    <= TRIGGER_SELECT_RESET;
            state_reg.polarity   <= POLARITY_RESET;
            state_reg.rdata      <= READ_DATA_RESET;
            state_reg.high       <= 1'b0;
            state_reg.low        <= 1'b0;
            state_reg.vector     <= VECTOR_BASE;
            state_reg.lines      <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sfr_rdata_out  = state_reg.rdata;
    assign irq_high_out   = state_reg.high;
    assign irq_low_out    = state_reg.low;
    assign irq_vector_out = state_reg.vector;
    assign irq_lines_out  = state_reg.lines;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // single lines stand for all: every line comes from the same loop and detector
    level_mirror_a: assert property (@(posedge clock_in) disable iff (srst_in)
        ($past(state_reg.trigger[0]) == TRIGGER_LEVEL && !$past(srst_in))
        |-> state_reg.pending[0] == $past(active_level[0]))
        else $error("level flag does not mirror pin");

    edge_hold_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (state_reg.trigger[1] && state_next.trigger[1] && state_reg.pending[1]
         && !(sfr_write_in && sfr_addr_in == PENDING_FLAGS_ADDR && sfr_wdata_in[1]))
        |=> state_reg.pending[1])
        else $error("edge flag dropped without clear");

    edge_clear_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (state_reg.trigger[2] && sfr_write_in && sfr_addr_in == PENDING_FLAGS_ADDR
         && sfr_wdata_in[2] && !edge_seen[2])
        |=> !state_reg.pending[2])
        else $error("edge flag not cleared by one");

    no_sw_set_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (state_reg.trigger[3] && !state_reg.pending[3] && !edge_seen[3])
        |=> !state_reg.pending[3])
        else $error("flag set without request");

    vector_range_a: assert property (@(posedge clock_in) disable iff (srst_in)
        state_reg.lines == 8'h80 |-> ##1 (state_reg.lines != 8'h80 || irq_vector_out == 8'ha3))
        else $error("wrong vector for line fourteen");

    enable_gate_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (state_reg.enables == 8'h00) |=> (!irq_high_out && !irq_low_out))
        else $error("request while disabled");

    prio_group_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (|(state_reg.pending & state_reg.enables & state_reg.priorities)) |=> irq_high_out)
        else $error("high group request missing");

    edge_polarity_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (edge_seen[4]) |-> (state_reg.trigger[4] &&
         ext_request_lines_seven_to_fourteen_in[4] == state_reg.polarity[4]))
        else $error("edge seen in wrong mode or sense");

    // a write of one must not drop a level flag while its pin is still active
    level_write_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (state_reg.trigger[5] == TRIGGER_LEVEL && active_level[5])
        |=> state_reg.pending[5])
        else $error("level flag lost while pin active");

    flag_rise_a: assert property (@(posedge clock_in) disable iff (srst_in)
        1'b1 |=> (state_reg.pending & ~$past(state_reg.pending) & $past(state_reg.trigger)
                  & ~$past(edge_seen)) == 8'h00)
        else $error("edge flag rose without an edge");

    vector_seven_a: assert property (@(posedge clock_in) disable iff (srst_in)
        irq_lines_out == 8'h01 |-> irq_vector_out == VECTOR_BASE)
        else $error("wrong vector for line seven");

    vector_idle_a: assert property (@(posedge clock_in) disable iff (srst_in)
        irq_lines_out == 8'h00 |-> irq_vector_out == VECTOR_BASE)
        else $error("idle vector not at line seven");

    low_group_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (|(state_reg.pending & state_reg.enables & ~state_reg.priorities)) |=> irq_low_out)
        else $error("low group request missing");

    lines_gate_a: assert property (@(posedge clock_in) disable iff (srst_in)
        1'b1 |=> (irq_lines_out & ~$past(state_reg.enables)) == 8'h00)
        else $error("disabled line requests service");

    level_no_edge_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (state_reg.trigger[6] == TRIGGER_LEVEL) |-> !edge_seen[6])
        else $error("edge seen on level line");
endmodule : ext_irq_bank

// *** test/ext_irq_requester.sv ***
// request source model driving the request pins
`timescale 1ns/100ps
module ext_irq_requester (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       srst_in,
    // bench control
    input  wire logic [7:0] set_in,
    input  wire logic [7:0] clear_in,
    input  wire logic       auto_release_in,
    // core side
    input  wire logic [7:0] serviced_in,
    // request pins
    output logic      [7:0] pins_out
);
    logic [7:0] pins_reg;
    logic [7:0] pins_next;
    always_comb begin
        pins_next = (pins_reg | set_in) & ~clear_in;
        // a level request goes away once the core takes the line
        if (auto_release_in) begin
            pins_next = pins_next & ~serviced_in;
        end
    end
    always_ff @(posedge clock_in) begin
        pins_reg <= srst_in ? 8'h00 : pins_next;
    end
    assign pins_out = pins_reg;
endmodule : ext_irq_requester

// *** test/ext_irq_bank_test.sv ***
// self-checking bench for the external interrupt bank
`timescale 1ns/100ps
module ext_irq_bank_test;
    import ext_irq_pkg::*;
    logic       clock_in = 1'b0;
    logic       srst_in  = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, set = 8'h00, clr = 8'h00;
    logic [7:0] rdata, vec, lines, pins;
    logic       wr = 1'b0, rd = 1'b0, auto_rel = 1'b0, hi, lo;
    int         mismatches = 0;
    int         checked    = 0;
    always #4 clock_in = ~clock_in;
    ext_irq_bank dut (.clock_in(clock_in), .srst_in(srst_in), .sfr_addr_in(addr), .sfr_write_in(wr),
        .sfr_read_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
        .ext_request_lines_seven_to_fourteen_in(pins), .irq_high_out(hi), .irq_low_out(lo),
        .irq_vector_out(vec), .irq_lines_out(lines));
    ext_irq_requester source (.clock_in(clock_in), .srst_in(srst_in), .set_in(set), .clear_in(clr),
        .auto_release_in(auto_rel), .serviced_in(lines), .pins_out(pins));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clock_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        #1 check(rdata, exp, what);
    endtask : rd_check
    // pins move one edge after the request, outputs settle two edges later
    task automatic pins_to(input logic [7:0] s, input logic [7:0] c);
        @(posedge clock_in);
        set <= s;
        clr <= c;
        @(posedge clock_in);
        set <= 8'h00;
        clr <= 8'h00;
        repeat (3) @(posedge clock_in);
        #1;
    endtask : pins_to
    task automatic cfg(input logic [7:0] trig, input logic [7:0] pol, input logic [7:0] en);
        wr_reg(TRIGGER_SELECT_ADDR, trig);
        wr_reg(POLARITY_ADDR, pol);
        wr_reg(ENABLES_ADDR, en);
        wr_reg(PRIORITIES_ADDR, 8'h00);
        repeat (2) @(posedge clock_in);
        #1;
    endtask : cfg
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_registers;
        check(vec, VECTOR_BASE, "reset vec");
        // low-active level lines see idle-low pins as requests one clock after reset
        rd_check(PENDING_FLAGS_ADDR, 8'hff, "reset mirror");
        for (int i = 1; i < 5; i++) rd_check(8'hf0 + i[7:0], 8'h00, "reset");
        for (int i = 1; i < 5; i++) begin
            wr_reg(8'hf0 + i[7:0], 8'h5a ^ i[7:0]);
            rd_check(8'hf0 + i[7:0], 8'h5a ^ i[7:0], "rw");
        end
        wr_reg(8'hf5, 8'hff);
        rd_check(8'hf5, 8'h00, "unmapped");
        $display("test_registers done");
    endtask : test_registers
    task automatic test_edge;
        cfg(8'hff, 8'hff, 8'hff);
        wr_reg(PENDING_FLAGS_ADDR, 8'hff);
        wr_reg(PENDING_FLAGS_ADDR, 8'hff);
        rd_check(PENDING_FLAGS_ADDR, 8'h00, "no sw set");
        pins_to(8'h81, 8'h00);
        pins_to(8'h00, 8'h81);
        wr_reg(PENDING_FLAGS_ADDR, 8'h7e);
        rd_check(PENDING_FLAGS_ADDR, 8'h81, "edge held");
        check({hi, lo, vec[5:0]}, 8'h6b, "low group");
        wr_reg(PENDING_FLAGS_ADDR, 8'h01);
        wr_reg(PRIORITIES_ADDR, 8'h80);
        repeat (2) @(posedge clock_in);
        #1 rd_check(PENDING_FLAGS_ADDR, 8'h80, "w1c");
        check({hi, lo, lines[7], vec[4:0]}, 8'ha3, "high group");
        check(vec, 8'ha3, "vec 14");
        $display("test_edge done");
    endtask : test_edge
    task automatic test_level;
        cfg(8'h00, 8'h00, 8'h00);
        rd_check(PENDING_FLAGS_ADDR, 8'hff, "low level");
        pins_to(8'h0f, 8'h00);
        wr_reg(PENDING_FLAGS_ADDR, 8'hff);
        rd_check(PENDING_FLAGS_ADDR, 8'hf0, "mirror");
        check({hi, lo, lines[5:0]}, 8'h00, "disabled");
        $display("test_level done");
    endtask : test_level
    task automatic test_vectors;
        cfg(8'h00, 8'hff, 8'h00);
        pins_to(8'h00, 8'hff);
        for (int i = 0; i < 8; i++) begin
            wr_reg(ENABLES_ADDR, 8'h01 << i);
            pins_to(8'h01 << i, 8'h00);
            check(vec, VECTOR_BASE + VECTOR_STEP * i[7:0], "vector");
            check({hi, lo, 6'h00} | (lines & 8'h00) | {2'b00, 6'h00}, 8'h40, "irq low");
            check(lines, 8'h01 << i, "lines");
            pins_to(8'h00, 8'h01 << i);
        end
        $display("test_vectors done");
    endtask : test_vectors
    task automatic test_release_and_fall;
        auto_rel <= 1'b1;
        cfg(8'h00, 8'hff, 8'h04);
        pins_to(8'h04, 8'h00);
        repeat (4) @(posedge clock_in);
        #1 check(pins, 8'h00, "released");
        rd_check(PENDING_FLAGS_ADDR, 8'h00, "follows");
        auto_rel <= 1'b0;
        pins_to(8'hff, 8'h00);
        cfg(8'hff, 8'h00, 8'h00);
        wr_reg(PENDING_FLAGS_ADDR, 8'hff);
        pins_to(8'h00, 8'h10);
        rd_check(PENDING_FLAGS_ADDR, 8'h10, "falling");
        $display("test_release_and_fall done");
    endtask : test_release_and_fall
    task automatic test_reset;
        wr_reg(ENABLES_ADDR, 8'hff);
        wr_reg(PRIORITIES_ADDR, 8'hff);
        repeat (2) @(posedge clock_in);
        #1 check({6'h00, hi, lo}, 8'h02, "high before reset");
        srst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        srst_in <= 1'b0;
        @(posedge clock_in);
        #1 check({6'h00, hi, lo}, 8'h00, "reset irq");
        check(lines, 8'h00, "reset lines");
        check(vec, VECTOR_BASE, "reset vec");
        rd_check(PENDING_FLAGS_ADDR, 8'hff, "reset mirror");
        for (int i = 1; i < 5; i++) rd_check(8'hf0 + i[7:0], 8'h00, "reset");
        $display("test_reset done");
    endtask : test_reset
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (3) @(posedge clock_in);
        srst_in <= 1'b0;
        @(posedge clock_in);
        #1 test_registers();
        test_edge();
        test_level();
        test_vectors();
        test_release_and_fall();
        test_reset();
        summarize();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock_in);
        mismatches++;
        summarize();
    end
endmodule : ext_irq_bank_test
